// File: logic/dsp_defines.svh
// constants for the multiply and multiply-accumulate element
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH

`define DSP_OP_W        18
`define DSP_GUARD_W     8

`define DSP_BUS_AW      4
`define DSP_BUS_DW      32

`define DSP_REG_CTRL    4'h0
`define DSP_REG_STAT    4'h1
`define DSP_REG_CLR     4'h2
`define DSP_REG_EN      4'h3
`define DSP_REG_RES_LO  4'h4
`define DSP_REG_RES_HI  4'h5
`define DSP_REG_FLAGS   4'h6

`define DSP_CTRL_RST    5'h0E
`define DSP_EN_RST      2'h0

`define DSP_IRQ_OVF     0
`define DSP_IRQ_LOAD    1
`define DSP_IRQ_N       2

`endif

// File: logic/dsp_multiply_only_element.sv
// signed or unsigned operand multiplier
`timescale 1ns/1ns
`include "dsp_defines.svh"

module dsp_multiply_only_element #(
  parameter int unsigned OP_W = `DSP_OP_W
) (
  input  wire logic [OP_W-1:0]   a,
  input  wire logic [OP_W-1:0]   b,
  input  wire logic              sgn,
  output logic      [2*OP_W-1:0] prod
);

  logic signed [OP_W:0]     a_x;
  logic signed [OP_W:0]     b_x;
  logic signed [2*OP_W+1:0] full;

  // one extra bit lets a single signed multiplier serve both cases
  assign a_x  = {sgn & a[OP_W-1], a};
  assign b_x  = {sgn & b[OP_W-1], b};
  assign full = a_x * b_x;
  assign prod = full[2*OP_W-1:0];

endmodule // dsp_multiply_only_element

// File: logic/dsp_pkg.sv
// types shared by the multiply-accumulate element
package dsp_pkg;

  typedef enum logic {
    DSP_MODE_MUL  = 1'b0,
    DSP_MODE_ACC  = 1'b1
  } dsp_mode_t;

  typedef struct packed {
    logic      serial;
    logic      out_reg;
    logic      pipe_reg;
    logic      in_reg;
    dsp_mode_t mode;
  } dsp_cfg_t;

  typedef struct packed {
    logic vld;
    logic ld;
    logic sub;
    logic sgn;
  } dsp_ctl_t;

endpackage

// File: logic/dsp_top.sv
// multiply-only and multiply-accumulate element with register port
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "dsp_defines.svh"

module dsp_top #(
  parameter int unsigned OP_W    = `DSP_OP_W,
  parameter int unsigned GUARD_W = `DSP_GUARD_W
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  input  wire logic [`DSP_BUS_AW-1:0]               reg_addr,
  input  wire logic [`DSP_BUS_DW-1:0]               reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [`DSP_BUS_DW-1:0]               reg_rdata,
  input  wire logic [OP_W-1:0]                      a_in,
  input  wire logic [OP_W-1:0]                      b_in,
  input  wire logic [OP_W-1:0]                      shift_a_in,
  input  wire logic [OP_W-1:0]                      shift_b_in,
  input  wire logic                                 sgn_in,
  input  wire logic                                 sub_in,
  input  wire logic                                 vld_in,
  input  wire logic                                 ld_in,
  input  wire logic [2*OP_W+GUARD_W-1:0]            ld_val,
  output logic      [2*OP_W+GUARD_W-1:0]            result_out,
  output logic                                      result_vld,
  output logic                                      ovf_out,
  output logic      [OP_W-1:0]                      shift_a_out,
  output logic      [OP_W-1:0]                      shift_b_out,
  output logic                                      irq
);

  localparam int unsigned PW = 2 * OP_W;
  localparam int unsigned AW = PW + GUARD_W;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  dsp_pkg::dsp_cfg_t        cfg_q;
  logic [`DSP_IRQ_N-1:0]    stat_q;
  logic [`DSP_IRQ_N-1:0]    stat_d;
  logic [`DSP_IRQ_N-1:0]    en_q;
  logic [`DSP_IRQ_N-1:0]    clr_mask;
  logic [`DSP_IRQ_N-1:0]    evt;
  logic [`DSP_BUS_DW-1:0]   rdata_q;
  logic                     irq_q;
  logic                     acc_on;
  logic [`DSP_IRQ_N-1:0]    en_d;
  dsp_pkg::dsp_ctl_t        ctl_in;
  logic [OP_W-1:0]          a_src;
  logic [OP_W-1:0]          b_src;
  logic [OP_W-1:0]          a_r;
  logic [OP_W-1:0]          b_r;
  dsp_pkg::dsp_ctl_t        c1_r;
  logic [AW-1:0]            ldv1_r;
  logic [OP_W-1:0]          a_s1;
  logic [OP_W-1:0]          b_s1;
  dsp_pkg::dsp_ctl_t        c_s1;
  logic [AW-1:0]            ldv_s1;
  logic [PW-1:0]            p_comb;
  logic [PW-1:0]            p_r;
  dsp_pkg::dsp_ctl_t        c2_r;
  logic [AW-1:0]            ldv2_r;
  logic [PW-1:0]            p_s2;
  dsp_pkg::dsp_ctl_t        c_s2;
  logic [AW-1:0]            ldv_s2;
  logic [AW-1:0]            ext_prod;
  logic [AW:0]              acc_x;
  logic [AW:0]              ep_x;
  logic [AW:0]              sum_x;
  logic                     ovf_now;
  logic                     acc_step;
  logic [AW-1:0]            acc_q;
  logic                     accv_q;
  logic                     ovf_q;
  logic [AW-1:0]            mout_q;
  logic                     mvld_q;
  logic [AW-1:0]            res_sel;
  logic [63:0]              res64;
  logic [OP_W-1:0]          sha_q;
  logic [OP_W-1:0]          shb_q;
  assign acc_on = (cfg_q.mode == dsp_pkg::DSP_MODE_ACC);

  ////////////////////////////////////////////////////////////////////////////
  // register port

  assign clr_mask = (reg_wr && reg_addr == `DSP_REG_CLR) ?
                    reg_wdata[`DSP_IRQ_N-1:0] : '0;
  // a new event beats a clear written in the same cycle
  assign stat_d   = (stat_q & ~clr_mask) | evt;
  assign en_d     = (reg_wr && reg_addr == `DSP_REG_EN) ? reg_wdata[`DSP_IRQ_N-1:0] : en_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= `DSP_CTRL_RST;
    end else if (reg_wr && reg_addr == `DSP_REG_CTRL) begin
      cfg_q <= reg_wdata[$bits(dsp_pkg::dsp_cfg_t)-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= `DSP_EN_RST;
    end else begin
      en_q <= en_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |(stat_d & en_d);
    end
  end

  // upper result word assumes the accumulator is at most 64 bits wide
  assign res64 = 64'(res_sel);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `DSP_REG_CTRL:   rdata_q <= 32'(cfg_q);
        `DSP_REG_STAT:   rdata_q <= 32'(stat_q);
        `DSP_REG_EN:     rdata_q <= 32'(en_q);
        `DSP_REG_RES_LO: rdata_q <= res64[31:0];
        `DSP_REG_RES_HI: rdata_q <= res64[63:32];
        `DSP_REG_FLAGS:  rdata_q <= 32'(ovf_q);
        default:         rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input stage

  assign ctl_in = '{vld: vld_in, ld: ld_in, sub: sub_in, sgn: sgn_in};
  assign a_src  = cfg_q.serial ? shift_a_in : a_in;
  assign b_src  = cfg_q.serial ? shift_b_in : b_in;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_r    <= '0;
      b_r    <= '0;
      c1_r   <= '0;
      ldv1_r <= '0;
    end else begin
      a_r    <= a_src;
      b_r    <= b_src;
      c1_r   <= ctl_in;
      ldv1_r <= ld_val;
    end
  end

  // the shift chain advances one element per clock in serial mode only; otherwise these flops forward a_in and b_in
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sha_q <= '0;
      shb_q <= '0;
    end else begin
      sha_q <= a_src;
      shb_q <= b_src;
    end
  end

  // controls travel with their operands so each-cycle switching stays aligned
  assign a_s1   = cfg_q.in_reg ? a_r : a_src;
  assign b_s1   = cfg_q.in_reg ? b_r : b_src;
  assign c_s1   = cfg_q.in_reg ? c1_r : ctl_in;
  assign ldv_s1 = cfg_q.in_reg ? ldv1_r : ld_val;

  dsp_multiply_only_element #(
    .OP_W (OP_W)
  ) u_multiply_only_element (
    .a    (a_s1),
    .b    (b_s1),
    .sgn  (c_s1.sgn),
    .prod (p_comb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pipeline stage

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      p_r    <= '0;
      c2_r   <= '0;
      ldv2_r <= '0;
    end else begin
      p_r    <= p_comb;
      c2_r   <= c_s1;
      ldv2_r <= ldv_s1;
    end
  end

  assign p_s2     = cfg_q.pipe_reg ? p_r : p_comb;
  assign c_s2     = cfg_q.pipe_reg ? c2_r : c_s1;
  assign ldv_s2   = cfg_q.pipe_reg ? ldv2_r : ldv_s1;
  assign ext_prod = {{GUARD_W{c_s2.sgn & p_s2[PW-1]}}, p_s2};

  ////////////////////////////////////////////////////////////////////////////
  // accumulator

  assign acc_x    = {c_s2.sgn & acc_q[AW-1], acc_q};
  assign ep_x     = {c_s2.sgn & ext_prod[AW-1], ext_prod};
  assign sum_x    = c_s2.sub ? (acc_x - ep_x) : (acc_x + ep_x);
  // signed: top two bits disagree; unsigned: carry or borrow out
  assign ovf_now  = c_s2.sgn ? (sum_x[AW] ^ sum_x[AW-1]) : sum_x[AW];
  assign acc_step = acc_on && c_s2.vld;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q  <= '0;
      accv_q <= 1'b0;
    end else begin
      accv_q <= acc_step;
      if (acc_step && c_s2.ld) begin
        acc_q <= ldv_s2;
      end else if (acc_step) begin
        acc_q <= sum_x[AW-1:0];
      end
    end
  end

  // sticky until the next reload so a wrap cannot go unnoticed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_q <= 1'b0;
    end else if (acc_step && c_s2.ld) begin
      ovf_q <= 1'b0;
    end else if (acc_step && ovf_now) begin
      ovf_q <= 1'b1;
    end
  end

  assign evt[`DSP_IRQ_OVF]  = acc_step && !c_s2.ld && ovf_now;
  assign evt[`DSP_IRQ_LOAD] = acc_step && c_s2.ld;

  ////////////////////////////////////////////////////////////////////////////
  // output stage

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mout_q <= '0;
      mvld_q <= 1'b0;
    end else begin
      mout_q <= ext_prod;
      mvld_q <= c_s2.vld;
    end
  end

  // in multiply mode a bypassed output stage is the one path that is not a flop
  always_comb begin
    if (acc_on) begin
      res_sel    = acc_q;
      result_vld = accv_q;
    end else if (cfg_q.out_reg) begin
      res_sel    = mout_q;
      result_vld = mvld_q;
    end else begin
      res_sel    = ext_prod;
      result_vld = c_s2.vld;
    end
  end

  assign result_out  = res_sel;
  assign ovf_out     = ovf_q;
  assign shift_a_out = sha_q;
  assign shift_b_out = shb_q;
  assign irq         = irq_q;
  assign reg_rdata   = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  function automatic logic [AW-1:0] ref_mul(logic [OP_W-1:0] a, logic [OP_W-1:0] b, logic s);
    logic signed [PW+1:0] f;
    f = $signed({s & a[OP_W-1], a}) * $signed({s & b[OP_W-1], b});
    return {{GUARD_W{s & f[PW-1]}}, f[PW-1:0]};
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_acc_load;
    acc_step && c_s2.ld;
  endsequence
  sequence s_acc_add;
    acc_step && !c_s2.ld && !c_s2.sub;
  endsequence
  sequence s_acc_sub;
    acc_step && !c_s2.ld && c_s2.sub;
  endsequence
  sequence s_mul_full;
    (!acc_on && cfg_q.in_reg && cfg_q.pipe_reg && cfg_q.out_reg)[*4];
  endsequence

  AST_MUL_BYPASS: assert property (
    (!acc_on && !cfg_q.in_reg && !cfg_q.pipe_reg && !cfg_q.out_reg) |->
      result_out == ref_mul(a_src, b_src, sgn_in))
    else $error("bypassed product wrong");
  AST_MUL_LATENCY: assert property (
    s_mul_full |->
      result_out == ref_mul($past(a_src, 3), $past(b_src, 3), $past(sgn_in, 3)))
    else $error("registered product latency wrong");
  AST_UNSIGNED_TOP: assert property (
    (!acc_on && !cfg_q.in_reg && !cfg_q.pipe_reg && !cfg_q.out_reg && !sgn_in) |->
      result_out[AW-1:PW] == '0)
    else $error("unsigned product has sign bits");
  AST_ACC_ADD: assert property (
    s_acc_add |=> acc_q == $past(acc_q) + $past(ext_prod))
    else $error("accumulate add wrong");
  AST_ACC_SUB: assert property (
    s_acc_sub |=> acc_q == $past(acc_q) - $past(ext_prod))
    else $error("accumulate subtract wrong");
  AST_ACC_OUT: assert property (
    (acc_on && !acc_step) |=> !acc_on || ($stable(result_out) && !result_vld))
    else $error("accumulate output not held in register");
  AST_ACC_LOAD: assert property (
    s_acc_load |=> acc_q == $past(ldv_s2) && !ovf_q)
    else $error("accumulator reload wrong");
  AST_OVF_SET: assert property (
    (acc_step && !c_s2.ld && ovf_now) |=> ovf_q && stat_q[`DSP_IRQ_OVF])
    else $error("overflow not captured");
  AST_OVF_HOLD: assert property (
    (ovf_q && !(acc_step && c_s2.ld)) |=> ovf_q)
    else $error("overflow dropped without reload");
  AST_SERIAL: assert property (
    cfg_q.serial |=> shift_a_out == $past(shift_a_in) && shift_b_out == $past(shift_b_in))
    else $error("serial shift broken");
  AST_IRQ: assert property (
    irq == |(stat_q & en_q))
    else $error("interrupt level mismatch");

endmodule // dsp_top

// File: testbench/dsp_fab_model.sv
// fabric-side model driving operands and controls
`timescale 1ns/1ns

module dsp_fab_model (
  input  wire logic        clk,
  output logic [17:0]      a,
  output logic [17:0]      b,
  output logic [17:0]      sa,
  output logic [17:0]      sb,
  output logic             sgn,
  output logic             sub,
  output logic             vld,
  output logic             ld,
  output logic [43:0]      ldv
);
  initial begin
    {a, b, sgn, sub, vld, ld, ldv} = '0;
    sa = 18'h0_0000;
  end

  // neighbour chain keeps moving, so a stuck shift path shows
  always @(posedge clk) begin
    sa <= sa + 18'h0_0001;
  end
  assign sb = ~sa;

  // one beat, launched after an edge; controls travel with operands
  task automatic op(input logic [17:0] av, input logic [17:0] bv, input logic s,
                    input logic m, input logic l, input logic [43:0] lv);
    @(posedge clk);
    a <= av;
    b <= bv;
    sgn <= s;
    sub <= m;
    ld <= l;
    ldv <= lv;
    vld <= 1'b1;
  endtask

  // operands not held after the beat
  task automatic idle();
    @(posedge clk);
    vld <= 1'b0;
    ld <= 1'b0;
    a <= ~a;
    b <= ~b;
    ldv <= ~ldv;
  endtask
endmodule // dsp_fab_model

// File: testbench/dsp_multiply_accumulate_tb_top.sv
// self-checking bench for the multiply-accumulate element
`timescale 1ns/1ns
`include "dsp_defines.svh"

module dsp_multiply_accumulate_tb_top;
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic [`DSP_BUS_AW-1:0] reg_addr = '0;
  logic [`DSP_BUS_DW-1:0] reg_wdata = '0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [`DSP_BUS_DW-1:0] reg_rdata;
  logic [17:0]            a, b, sa, sb, sao, sbo, xa;
  logic                   sgn, sub, vld, ld, rvld, ovf, irq;
  logic [43:0]            ldv, res;
  logic [31:0]            rv;
  int                     error_cnt = 0;
  int                     cmp_count = 0;

  always #4 clk = ~clk;

  dsp_fab_model u_fab (.clk(clk), .a(a), .b(b), .sa(sa), .sb(sb), .sgn(sgn), .sub(sub),
                       .vld(vld), .ld(ld), .ldv(ldv));

  dsp_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                 .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .a_in(a),
                 .b_in(b), .shift_a_in(sa), .shift_b_in(sb), .sgn_in(sgn), .sub_in(sub),
                 .vld_in(vld), .ld_in(ld), .ld_val(ldv), .result_out(res),
                 .result_vld(rvld), .ovf_out(ovf), .shift_a_out(sao),
                 .shift_b_out(sbo), .irq(irq));

  task automatic chk(input string nm, input logic [43:0] e, input logic [43:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [3:0] ad, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, {12'h000, e}, {12'h000, reg_rdata});
  endtask

  // one accumulate beat, latency one clock with in and pipe stages off
  task automatic acc(input logic [17:0] av, input logic [17:0] bv, input logic s,
                     input logic m, input logic l, input logic [43:0] lv);
    u_fab.op(av, bv, s, m, l, lv);
    u_fab.idle();
    #1 chk("acc_vld", 44'h1, {43'h0, rvld});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #40000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdchk("ctrl", `DSP_REG_CTRL, 32'h0000_000E);
    rdchk("en", `DSP_REG_EN, 32'h0000_0000);
    rdchk("unmapped", 4'h7, 32'h0000_0000);
    $display("test reset done");
    // three stages: products stream out, nothing summed
    u_fab.op(18'h0_0003, 18'h0_0005, 1'b0, 1'b0, 1'b0, '0);
    u_fab.op(18'h3_FFFE, 18'h0_0003, 1'b0, 1'b0, 1'b0, '0);
    u_fab.op(18'h3_FFFE, 18'h0_0003, 1'b1, 1'b0, 1'b0, '0);
    u_fab.idle();
    #1 chk("mul0", 44'h0_0000_0000_0F, {8'h00, res[35:0]});
    chk("mul_vld", 44'h1, {43'h0, rvld});
    @(posedge clk);
    #1 chk("mul1", 44'h0_0000_000B_FFFA, {8'h00, res[35:0]});
    @(posedge clk);
    #1 chk("mul2", 44'h0_000F_FFFF_FFFA, {8'h00, res[35:0]});
    wr(`DSP_REG_CTRL, 32'h0000_0000);
    u_fab.op(18'h0_0006, 18'h0_0007, 1'b0, 1'b0, 1'b0, '0);
    #1 chk("bypass", 44'h0_0000_0000_2A, {8'h00, res[35:0]});
    u_fab.idle();
    $display("test multiply done");
    wr(`DSP_REG_CTRL, 32'h0000_0001);
    wr(`DSP_REG_EN, 32'h0000_0001);
    acc(18'h0_0000, 18'h0_0000, 1'b0, 1'b0, 1'b1, 44'h0_0000_0000_64);
    chk("load", 44'h0_0000_0000_64, res);
    chk("masked", 44'h0, {43'h0, irq});
    acc(18'h0_0003, 18'h0_0005, 1'b0, 1'b0, 1'b0, '0);
    chk("add", 44'h0_0000_0000_73, res);
    acc(18'h0_0002, 18'h0_0002, 1'b0, 1'b1, 1'b0, '0);
    chk("sub", 44'h0_0000_0000_6F, res);
    acc(18'h3_FFFD, 18'h0_0004, 1'b1, 1'b0, 1'b0, '0);
    chk("sgn_add", 44'h0_0000_0000_63, res);
    @(posedge clk);
    #1 chk("hold", 44'h0_0000_0000_63, res);
    rdchk("res_lo", `DSP_REG_RES_LO, 32'h0000_0063);
    acc(18'h0_0000, 18'h0_0000, 1'b0, 1'b0, 1'b1, 44'h0);
    acc(18'h0_0001, 18'h0_0001, 1'b0, 1'b1, 1'b0, '0);
    chk("borrow", 44'hF_FFFF_FFFF_FF, res);
    chk("ovf", 44'h1, {43'h0, ovf});
    chk("irq", 44'h1, {43'h0, irq});
    rdchk("res_hi", `DSP_REG_RES_HI, 32'h0000_0FFF);
    rdchk("stat", `DSP_REG_STAT, 32'h0000_0003);
    rdchk("flags", `DSP_REG_FLAGS, 32'h0000_0001);
    wr(`DSP_REG_CLR, 32'h0000_0003);
    #1 chk("irq_clr", 44'h0, {43'h0, irq});
    rdchk("stat_clr", `DSP_REG_STAT, 32'h0000_0000);
    acc(18'h0_0000, 18'h0_0000, 1'b0, 1'b0, 1'b1, 44'h0_0000_0000_05);
    chk("ovf_clr", 44'h0, {43'h0, ovf});
    rdchk("stat_ld", `DSP_REG_STAT, 32'h0000_0002);
    $display("test accumulate done");
    wr(`DSP_REG_CTRL, 32'h0000_0011);
    @(negedge clk);
    xa = sa;
    @(posedge clk);
    #1 chk("shift_a", {26'h0, xa}, {26'h0, sao});
    chk("shift_b", {26'h0, ~xa}, {26'h0, sbo});
    $display("test serial done");
    // input and pipeline stages on: two extra clocks before the sum moves
    wr(`DSP_REG_CTRL, 32'h0000_0007);
    u_fab.op(18'h0_0000, 18'h0_0000, 1'b0, 1'b0, 1'b1, 44'h0_0000_0000_10);
    u_fab.op(18'h0_0002, 18'h0_0003, 1'b0, 1'b0, 1'b0, '0);
    u_fab.idle();
    #1 chk("staged_gap", 44'h0_0000_0000_05, res);
    chk("staged_novld", 44'h0, {43'h0, rvld});
    @(posedge clk);
    #1 chk("staged_load", 44'h0_0000_0000_10, res);
    @(posedge clk);
    #1 chk("staged_add", 44'h0_0000_0000_16, res);
    chk("staged_vld", 44'h1, {43'h0, rvld});
    $display("test staged done");
    tally_and_finish();
  end
endmodule // dsp_multiply_accumulate_tb_top
